/* File: sbcc_pkg.sv */
// sbcc_pkg: frame layout, field positions, reset values and codes for the
// configuration/diagnosis register encoders.
// assumes a 16-bit serial frame, least significant bit shifted first.
`default_nettype none

package sbcc_pkg;

    // frame layout
    localparam int FRAME_BITS      = 16;
    localparam int MODE_LSB        = 0;
    localparam int SEL_LSB         = 3;
    localparam int DATA_LSB        = 6;
    localparam int DATA_BITS       = 10;

    // mode selection code for a read-only command
    localparam logic [2:0] MODE_READ_ONLY = 3'h7;

    // configuration selects
    localparam logic [2:0] SEL_SBC_CONFIG = 3'h4;
    localparam logic [2:0] SEL_COMM_SETUP = 3'h5;
    localparam logic [2:0] SEL_WD_SETUP   = 3'h6;
    localparam logic [2:0] SEL_DIAGNOSIS  = 3'h7;

    // field positions inside the frame
    localparam int COMM_SLOPE_POS  = 6;
    localparam int COMM_CAN_LSB    = 7;
    localparam int COMM_LIN_LSB    = 9;
    localparam int WD_PERIOD_LSB   = 6;
    localparam int WD_TOW_POS      = 11;
    localparam int WD_RSVD_POS     = 12;
    localparam int WD_EN_POS       = 13;
    localparam int WD_PARITY_POS   = 14;
    localparam int WD_PARITY_LSB   = 6;
    localparam int WD_PARITY_MSB   = 13;
    localparam int CFG_THR_LSB     = 6;
    localparam int CFG_LIMP_POS    = 11;
    localparam int CFG_WD2LH_POS   = 13;

    // reset values
    localparam logic       COMM_SLOPE_RST  = 1'b1;
    localparam logic [1:0] CELL_MODE_RST   = 2'h0;
    localparam logic       WD_TOW_RST      = 1'b1;
    localparam logic       WD_RSVD_VAL     = 1'b1;
    localparam logic       WD_EN_RST       = 1'b1;
    localparam logic [4:0] WD_PERIOD_RST   = 5'h0f;
    localparam logic [1:0] THR_RST         = 2'h1;
    localparam logic [1:0] THR_INVALID     = 2'h0;
    localparam logic       LIMP_RST        = 1'b0;
    localparam logic       WD2LH_RST       = 1'b1;

    // watchdog period encoding, in ms
    localparam int         WD_STEP_LO_MS   = 16;
    localparam int         WD_STEP_HI_MS   = 48;
    localparam int         WD_OFFSET_HI_MS = 464;
    localparam logic [4:0] WD_CODE_SPLIT   = 5'h10;
    localparam int         WD_MS_BITS      = 11;

    // diagnosis codes
    localparam logic [1:0] RESTART_NONE    = 2'h0;
    localparam logic [2:0] LIMP_NONE       = 3'h0;
    localparam int         STRAP_DEV_POS   = 2;

endpackage : sbcc_pkg

`default_nettype wire

/* File: sbcc_sync.sv */
// sbcc_sync: two-flop level synchroniser, one lane per bit.
// assumes each lane is a level that stays put for several destination clocks.
`default_nettype none
`timescale 1ns/1ps

module sbcc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // the first stage feeds only the second stage
    always_ff @(posedge clk) begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
    end

endmodule // sbcc_sync

`default_nettype wire

/* File: sbcc_encoders.sv */
// sbcc_encoders: configuration and diagnosis register encoders behind the serial link.
// assumes the host is serial master, drives spi_clk only inside frames, samples sdo on
// the falling edge, and frames are 16 bits, least significant bit first.
`default_nettype none
`timescale 1ns/1ps

module sbcc_encoders (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // serial link, host side
    input  wire logic       spi_clk,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_sdi,
    output logic            spi_sdo,
    output logic            spi_sdo_oe,
    // diagnosis events from the device core (same clock)
    input  wire logic       restart_evt,
    input  wire logic [1:0] restart_cause_in,
    input  wire logic       limp_evt,
    input  wire logic [2:0] limp_cause_in,
    input  wire logic       mode_exit_clear,
    // strap pins
    input  wire logic [1:0] int_pin_strap,
    input  wire logic       test_pin,
    // decoded settings
    output logic            lin_low_slope,
    output logic [1:0]      can_mode,
    output logic [1:0]      lin_cell_mode,
    output logic            wd_timeout_or_window,
    output logic            wd_enable,
    output logic [4:0]      wd_period_code,
    output logic [10:0]     wd_period_ms,
    output logic            threshold_level_1,
    output logic            threshold_level_2,
    output logic            threshold_level_3,
    output logic            limp_home_output,
    output logic            wd_fail_to_limp,
    output logic            wd_fail_reset_inhibit
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [10:0] wd_ms(input logic [4:0] n);
        logic [10:0] n_ext;
        n_ext = {6'h00, n};
        if (n < sbcc_pkg::WD_CODE_SPLIT) begin
            wd_ms = 11'((n_ext + 11'h001) * 11'(sbcc_pkg::WD_STEP_LO_MS));
        end else begin
            wd_ms = 11'(n_ext * 11'(sbcc_pkg::WD_STEP_HI_MS) - 11'(sbcc_pkg::WD_OFFSET_HI_MS));
        end
    endfunction

    function automatic logic wd_parity(input logic [15:0] f);
        wd_parity = ^f[sbcc_pkg::WD_PARITY_MSB:sbcc_pkg::WD_PARITY_LSB];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: shift in, shift out

    logic [4:0]  bit_cnt_reg;
    logic [15:0] rx_shift_reg;
    logic [15:0] tx_shift_reg;
    logic [15:0] frame_hold_reg;
    logic        frame_done_reg;
    logic [2:0]  last_sel_reg;
    logic [9:0]  rb_config_reg;
    logic [9:0]  rb_comm_reg;
    logic [9:0]  rb_wd_reg;
    logic [9:0]  rb_diag_reg;
    logic [15:0] rx_now;
    logic        ro_hit;
    logic [9:0]  ro_data;

    function automatic logic [9:0] readback(input logic [2:0] sel, input logic [9:0] cfg,
                                            input logic [9:0] comm, input logic [9:0] wd,
                                            input logic [9:0] diag);
        unique case (sel)
            sbcc_pkg::SEL_SBC_CONFIG: readback = cfg;
            sbcc_pkg::SEL_COMM_SETUP: readback = comm;
            sbcc_pkg::SEL_WD_SETUP:   readback = wd;
            sbcc_pkg::SEL_DIAGNOSIS:  readback = diag;
            default:                  readback = 10'h000;
        endcase
    endfunction

    assign rx_now = {spi_sdi, rx_shift_reg[15:1]};

    // cs_n high clears the bit count; the link clock is dead between frames
    always_ff @(posedge spi_clk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_cnt_reg <= 5'h00;
        end else if (bit_cnt_reg != 5'(sbcc_pkg::FRAME_BITS)) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge spi_clk) begin
        rx_shift_reg <= rx_now;
    end

    always_ff @(posedge spi_clk) begin
        if (bit_cnt_reg == 5'(sbcc_pkg::FRAME_BITS - 1)) begin
            frame_hold_reg <= rx_now;
        end
    end

    // a level, not a toggle: cs_n high clears it, so it needs no reset of its own;
    // limitation: cs_n must stay low three core clocks after the last link edge
    always_ff @(posedge spi_clk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            frame_done_reg <= 1'b0;
        end else if (bit_cnt_reg == 5'(sbcc_pkg::FRAME_BITS - 1)) begin
            frame_done_reg <= 1'b1;
        end
    end

    // after six edges the mode and select of this frame sit in rx_shift_reg[15:10]
    assign ro_hit  = bit_cnt_reg == 5'(sbcc_pkg::DATA_LSB) &&
                     rx_shift_reg[12:10] == sbcc_pkg::MODE_READ_ONLY;
    assign ro_data = readback(rx_shift_reg[15:13], rb_config_reg, rb_comm_reg, rb_wd_reg, rb_diag_reg);

    // readback words are frozen by the core while cs_n is low, so sampling them here is safe;
    // tx_shift_reg holds the bits still to go, answer bit k leaves on edge k
    always_ff @(posedge spi_clk) begin
        if (bit_cnt_reg == 5'h00) begin
            tx_shift_reg <= {1'b0, readback(last_sel_reg, rb_config_reg, rb_comm_reg, rb_wd_reg, rb_diag_reg),
                             last_sel_reg, 2'h0};
        end else if (ro_hit) begin
            tx_shift_reg <= {7'h00, ro_data[9:1]};
        end else begin
            tx_shift_reg <= {1'b0, tx_shift_reg[15:1]};
        end
    end

    always_ff @(posedge spi_clk) begin
        if (bit_cnt_reg == 5'h00) begin
            // answer mode bits are always zero
            spi_sdo <= 1'b0;
        end else if (ro_hit) begin
            spi_sdo <= ro_data[0];
        end else begin
            spi_sdo <= tx_shift_reg[0];
        end
    end

    // output enable follows chip select so the line is released with no link clock
    assign spi_sdo_oe = ~spi_cs_n;

    ////////////////////////////////////////////////////////////////////////////////
    // crossings into the core domain

    logic [1:0] strap_cfg_sync;
    logic       test_pin_sync;
    logic       cs_n_sync;
    logic       done_sync;
    logic       done_seen_reg;
    logic       frame_pulse;

    sbcc_sync #(.WIDTH(5)) u_sync (
        .clk      (core_clk),
        .async_in ({int_pin_strap, test_pin, spi_cs_n, frame_done_reg}),
        .sync_out ({strap_cfg_sync, test_pin_sync, cs_n_sync, done_sync})
    );

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            done_seen_reg <= 1'b0;
        end else begin
            done_seen_reg <= done_sync;
        end
    end

    // rising edge of the done level; frame_hold_reg stays put until the next frame's last edge
    assign frame_pulse = done_sync & ~done_seen_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // command decode

    logic [15:0] f;
    logic        is_read_only;
    logic        is_write;
    logic [2:0]  sel;

    assign f            = frame_hold_reg;
    assign sel          = f[5:3];
    assign is_read_only = frame_pulse && f[2:0] == sbcc_pkg::MODE_READ_ONLY;
    assign is_write     = frame_pulse && f[2:0] != sbcc_pkg::MODE_READ_ONLY;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            last_sel_reg <= sbcc_pkg::SEL_SBC_CONFIG;
        end else if (frame_pulse) begin
            last_sel_reg <= sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // communication set-up

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lin_low_slope <= sbcc_pkg::COMM_SLOPE_RST;
            can_mode      <= sbcc_pkg::CELL_MODE_RST;
            lin_cell_mode <= sbcc_pkg::CELL_MODE_RST;
        end else if (is_write && sel == sbcc_pkg::SEL_COMM_SETUP) begin
            lin_low_slope <= f[sbcc_pkg::COMM_SLOPE_POS];
            can_mode      <= f[sbcc_pkg::COMM_CAN_LSB +: 2];
            lin_cell_mode <= f[sbcc_pkg::COMM_LIN_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog set-up

    logic wd_cmd_ok;

    assign wd_cmd_ok = is_write && sel == sbcc_pkg::SEL_WD_SETUP &&
                       f[sbcc_pkg::WD_PARITY_POS] == wd_parity(f);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wd_timeout_or_window <= sbcc_pkg::WD_TOW_RST;
            wd_enable            <= sbcc_pkg::WD_EN_RST;
            wd_period_code       <= sbcc_pkg::WD_PERIOD_RST;
            wd_period_ms         <= wd_ms(sbcc_pkg::WD_PERIOD_RST);
        end else if (wd_cmd_ok) begin
            wd_timeout_or_window <= f[sbcc_pkg::WD_TOW_POS];
            wd_enable            <= f[sbcc_pkg::WD_EN_POS];
            wd_period_code       <= f[sbcc_pkg::WD_PERIOD_LSB +: 5];
            wd_period_ms         <= wd_ms(f[sbcc_pkg::WD_PERIOD_LSB +: 5]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration: reset threshold, limp output

    logic [1:0] thr_sel_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            thr_sel_reg <= sbcc_pkg::THR_RST;
        end else if (is_write && sel == sbcc_pkg::SEL_SBC_CONFIG &&
                     f[sbcc_pkg::CFG_THR_LSB +: 2] != sbcc_pkg::THR_INVALID) begin
            thr_sel_reg <= f[sbcc_pkg::CFG_THR_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            threshold_level_1 <= 1'b1;
            threshold_level_2 <= 1'b0;
            threshold_level_3 <= 1'b0;
        end else begin
            threshold_level_1 <= thr_sel_reg == 2'h1;
            threshold_level_2 <= thr_sel_reg == 2'h2;
            threshold_level_3 <= thr_sel_reg == 2'h3;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            limp_home_output <= sbcc_pkg::LIMP_RST;
            wd_fail_to_limp  <= sbcc_pkg::WD2LH_RST;
        end else begin
            // an event raises the output even if a write clears it in the same cycle
            if (limp_evt) begin
                limp_home_output <= 1'b1;
            end else if (is_write && sel == sbcc_pkg::SEL_SBC_CONFIG) begin
                limp_home_output <= f[sbcc_pkg::CFG_LIMP_POS];
            end
            if (is_write && sel == sbcc_pkg::SEL_SBC_CONFIG) begin
                wd_fail_to_limp <= f[sbcc_pkg::CFG_WD2LH_POS];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // diagnosis

    logic [1:0] restart_cause_reg;
    logic [2:0] limp_cause_reg;
    logic [2:0] strap_reg;
    logic       strap_taken_reg;
    logic       limp_off_cmd;

    assign limp_off_cmd = is_write && sel == sbcc_pkg::SEL_SBC_CONFIG && !f[sbcc_pkg::CFG_LIMP_POS];

    // a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            restart_cause_reg <= sbcc_pkg::RESTART_NONE;
        end else if (restart_evt) begin
            restart_cause_reg <= restart_cause_in;
        end else if ((is_read_only && sel == sbcc_pkg::SEL_DIAGNOSIS) ||
                     mode_exit_clear) begin
            restart_cause_reg <= sbcc_pkg::RESTART_NONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            limp_cause_reg <= sbcc_pkg::LIMP_NONE;
        end else if (limp_evt) begin
            limp_cause_reg <= limp_cause_in;
        end else if (limp_off_cmd) begin
            limp_cause_reg <= sbcc_pkg::LIMP_NONE;
        end
    end

    // straps are caught once, a clock after reset is released
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            strap_taken_reg <= 1'b0;
            strap_reg       <= 3'h0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            strap_reg       <= {test_pin_sync, strap_cfg_sync};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wd_fail_reset_inhibit <= 1'b0;
        end else begin
            wd_fail_reset_inhibit <= strap_reg[sbcc_pkg::STRAP_DEV_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // readback words, frozen while a frame is running

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rb_config_reg <= 10'h000;
            rb_comm_reg   <= 10'h000;
            rb_wd_reg     <= 10'h000;
            rb_diag_reg   <= 10'h000;
        end else if (cs_n_sync) begin
            rb_config_reg <= {2'h0, wd_fail_to_limp, 1'b0, limp_home_output, 3'h0, thr_sel_reg};
            rb_comm_reg   <= {5'h00, lin_cell_mode, can_mode, lin_low_slope};
            rb_wd_reg     <= {1'b0, ^{wd_enable, sbcc_pkg::WD_RSVD_VAL, wd_timeout_or_window, wd_period_code},
                              wd_enable, sbcc_pkg::WD_RSVD_VAL, wd_timeout_or_window, wd_period_code};
            rb_diag_reg   <= {1'b0, wd_fail_to_limp, strap_reg, limp_cause_reg, restart_cause_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    AST_SLOPE_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_write && sel == sbcc_pkg::SEL_COMM_SETUP |=> lin_low_slope == $past(f[6]))
        else $error("slope bit not taken");

    AST_CAN_LIN_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_write && sel == sbcc_pkg::SEL_COMM_SETUP |=> can_mode == $past(f[8:7]) && lin_cell_mode == $past(f[10:9]))
        else $error("cell modes not taken");

    AST_LIN_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(is_write && sel == sbcc_pkg::SEL_COMM_SETUP) |=> $stable(lin_cell_mode))
        else $error("lin mode changed without a write");

    AST_WD_BAD_PARITY: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_write && sel == sbcc_pkg::SEL_WD_SETUP && f[14] != ^f[13:6]
        |=> $stable(wd_enable) && $stable(wd_period_code) && $stable(wd_timeout_or_window))
        else $error("bad parity changed watchdog");

    AST_WD_GOOD: assert property (@(posedge core_clk) disable iff (!rst_n)
        wd_cmd_ok |=> wd_enable == $past(f[13]) && wd_timeout_or_window == $past(f[11]))
        else $error("watchdog bits not taken");

    AST_THR_INVALID: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_write && sel == sbcc_pkg::SEL_SBC_CONFIG && f[7:6] == 2'h0 |=> $stable(thr_sel_reg))
        else $error("invalid threshold taken");

    AST_THR_ONEHOT: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##1 $onehot({threshold_level_1, threshold_level_2, threshold_level_3}))
        else $error("threshold levels not one-hot");

    AST_PERIOD_MS: assert property (@(posedge core_clk) disable iff (!rst_n)
        wd_cmd_ok && f[10:6] == 5'h1f |=> wd_period_ms == 11'h400)
        else $error("period 31 not 1024 ms");

    AST_RESTART_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_read_only && sel == sbcc_pkg::SEL_DIAGNOSIS && !restart_evt |=> restart_cause_reg == 2'h0)
        else $error("restart cause not cleared by read");

    AST_EXIT_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode_exit_clear && !restart_evt |=> restart_cause_reg == 2'h0)
        else $error("restart cause not cleared on exit");

    AST_LIMP_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
        limp_off_cmd && !limp_evt |=> limp_cause_reg == 3'h0)
        else $error("limp cause not cleared");

    AST_DIAG_IGNORED: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_write && sel == sbcc_pkg::SEL_DIAGNOSIS && !restart_evt && !limp_evt && !mode_exit_clear
        |=> $stable(restart_cause_reg) && $stable(limp_cause_reg) && $stable(can_mode) && $stable(wd_enable))
        else $error("diagnosis write changed state");

endmodule // sbcc_encoders

`default_nettype wire

/* File: sbcc_host.sv */
// sbcc_host: host-side serial master model that drives frames into the encoders.
// assumes the device shifts sdo after spi_clk rising; this model samples it on falling.
`timescale 1ns/1ps
`default_nettype none

module sbcc_host (
    output logic      spi_clk,
    output logic      spi_cs_n,
    output logic      spi_sdi,
    input  wire logic spi_sdo
);
    initial begin
        spi_clk  = 1'b0;
        spi_sdi  = 1'b0;
        // one rising edge of cs_n at power-up clears the link counter
        #1 spi_cs_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock runs only inside frames; sdi drops to its pull-down level between them
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        spi_cs_n = 1'b0;
        #25.3;
        for (int k = 0; k < 16; k++) begin
            spi_sdi = tx[k];
            #24 spi_clk = 1'b1;
            #24 spi_clk = 1'b0;
            rx[k] = spi_sdo;
        end
        spi_sdi  = 1'b0;
        spi_cs_n = 1'b1;
        #100;
    endtask
endmodule // sbcc_host

`default_nettype wire

/* File: sbcc_encoders_tb.sv */
// sbcc_encoders_tb: self-checking bench for the configuration and diagnosis encoders.
// assumes sbcc_host drives the link; core-side inputs change on falling core_clk.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("unexpected at %0t: value mismatch", $time); end end

module sbcc_encoders_tb;
    logic        core_clk = 1'b0, rst_n = 1'b0, restart_evt = 1'b0, limp_evt = 1'b0, mode_exit_clear = 1'b0;
    logic [1:0]  restart_cause_in = 2'h0, int_pin_strap = 2'h2;
    logic [2:0]  limp_cause_in = 3'h0;
    logic        test_pin = 1'b0, spi_clk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe, lin_low_slope;
    logic        wd_timeout_or_window, wd_enable, threshold_level_1, threshold_level_2, threshold_level_3;
    logic        limp_home_output, wd_fail_to_limp, wd_fail_reset_inhibit;
    logic [1:0]  can_mode, lin_cell_mode;
    logic [4:0]  wd_period_code;
    logic [10:0] wd_period_ms;
    logic [15:0] rx;
    int          fail_count = 0, n_checks = 0;

    always #2 core_clk = ~core_clk;

    sbcc_encoders u_dut (.core_clk, .rst_n, .spi_clk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe,
        .restart_evt, .restart_cause_in, .limp_evt, .limp_cause_in, .mode_exit_clear, .int_pin_strap,
        .test_pin, .lin_low_slope, .can_mode, .lin_cell_mode, .wd_timeout_or_window, .wd_enable,
        .wd_period_code, .wd_period_ms, .threshold_level_1, .threshold_level_2, .threshold_level_3,
        .limp_home_output, .wd_fail_to_limp, .wd_fail_reset_inhibit);
    sbcc_host u_host (.spi_clk, .spi_cs_n, .spi_sdi, .spi_sdo);

    ////////////////////////////////////////////////////////////////////////////////
    // frames start on a falling core edge so later checks never land on a rising one
    task automatic wr(input logic [2:0] sel, input logic [9:0] d);
        @(negedge core_clk);
        u_host.frame({d, sel, 3'h0}, rx);
    endtask
    task automatic rd(input logic [2:0] sel);
        @(negedge core_clk);
        u_host.frame({10'h0, sel, sbcc_pkg::MODE_READ_ONLY}, rx);
    endtask
    // host always sends the reserved bit as one and a correct parity unless told otherwise
    function automatic logic [9:0] wdd(logic [4:0] p, logic t, logic e, logic bad);
        return {1'b0, ^{e, 1'b1, t, p} ^ bad, e, 1'b1, t, p};
    endfunction

    task automatic t_reset(input logic dev);
        `CHK({lin_low_slope, can_mode, lin_cell_mode}, 5'h10)
        `CHK({wd_timeout_or_window, wd_enable}, 2'h3)
        `CHK(wd_period_ms, 11'h100)
        `CHK({threshold_level_3, threshold_level_2, threshold_level_1}, 3'h1)
        `CHK(wd_fail_reset_inhibit, dev)
    endtask

    // mid-run reset with the test pin high: straps taken again, development mode read back
    task automatic t_dev();
        @(negedge core_clk);
        {rst_n, test_pin} = 2'h1;
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        t_reset(1'b1);
        rd(sbcc_pkg::SEL_DIAGNOSIS);
        `CHK(rx[5:3], sbcc_pkg::SEL_SBC_CONFIG)
        `CHK(rx[13:11], 3'h6)
    endtask

    task automatic t_comm();
        for (int i = 0; i < 4; i++) begin
            wr(sbcc_pkg::SEL_COMM_SETUP, {5'h0, i[1:0], ~i[1:0], i[0]});
            `CHK(can_mode, ~i[1:0])
            `CHK(lin_cell_mode, i[1:0])
            `CHK(lin_low_slope, i[0])
            rd(sbcc_pkg::SEL_COMM_SETUP);
            `CHK(rx[10:6], {i[1:0], ~i[1:0], i[0]})
        end
        wr(sbcc_pkg::SEL_DIAGNOSIS, 10'h000);
        `CHK(rx[10:3], {2'h3, 2'h0, 1'b1, sbcc_pkg::SEL_COMM_SETUP})
    endtask

    task automatic t_wd();
        logic [4:0] c[4] = '{5'h00, 5'h0f, 5'h10, 5'h1f};
        for (int i = 0; i < 4; i++) begin
            wr(sbcc_pkg::SEL_WD_SETUP, wdd(c[i], i[0], ~i[0], 1'b0));
            `CHK(wd_period_ms, c[i] < 5'h10 ? 11'((c[i] + 1) * 16) : 11'(c[i] * 48 - 464))
            `CHK({wd_timeout_or_window, wd_enable}, {i[0], ~i[0]})
        end
        wr(sbcc_pkg::SEL_WD_SETUP, wdd(5'h03, 1'b0, 1'b1, 1'b1));
        `CHK({wd_period_code, wd_timeout_or_window, wd_enable}, 7'h7e)
        rd(sbcc_pkg::SEL_WD_SETUP);
        `CHK(rx[12], 1'b1)
    endtask

    task automatic t_thr();
        for (int i = 1; i < 5; i++) begin
            wr(sbcc_pkg::SEL_SBC_CONFIG, {2'h0, 1'b1, 5'h0, 2'(i % 4)});
            `CHK({threshold_level_3, threshold_level_2, threshold_level_1}, 3'(1 << ((i > 3 ? 3 : i) - 1)))
        end
    endtask

    task automatic t_diag();
        @(negedge core_clk);
        {restart_evt, restart_cause_in, limp_evt, limp_cause_in} = 7'h6d;
        @(negedge core_clk);
        {restart_evt, limp_evt} = 2'h0;
        wr(sbcc_pkg::SEL_DIAGNOSIS, 10'h3ff);
        `CHK({limp_home_output, lin_cell_mode, wd_period_code}, 8'hff)
        rd(sbcc_pkg::SEL_DIAGNOSIS);
        `CHK(rx[14:6], {1'b1, 3'h2, 3'h5, 2'h2})
        rd(sbcc_pkg::SEL_DIAGNOSIS);
        `CHK(rx[7:6], 2'h0)
        @(negedge core_clk);
        {restart_evt, restart_cause_in} = 3'h5;
        @(negedge core_clk);
        {restart_evt, mode_exit_clear} = 2'h1;
        @(negedge core_clk);
        mode_exit_clear = 1'b0;
        rd(sbcc_pkg::SEL_DIAGNOSIS);
        `CHK(rx[7:6], 2'h0)
        wr(sbcc_pkg::SEL_SBC_CONFIG, {2'h0, 1'b1, 5'h0, 2'h1});
        rd(sbcc_pkg::SEL_DIAGNOSIS);
        `CHK({limp_home_output, rx[10:8]}, 4'h0)
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end

    initial begin
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        t_reset(1'b0);
        t_comm();
        t_wd();
        t_thr();
        t_diag();
        t_dev();
        end_of_test();
    end
endmodule // sbcc_encoders_tb

`default_nettype wire
